// ==== src/dfcc_cfg.svh ====
// Purpose: constants for the daisy frame crc check block
// Assumes: byte-wide frame stream on the device clock
// Notes: behaviour of the block is listed below
// Behaviour
// - crc-16, poly x^16+x^15+x^2+1, reflected 0xa001 form, preset all ones.
// - receiver checks whole frame including crc bytes; zero remainder means good.
// - check evaluated first; failed frame dropped, command never executed.
// - failed frame gets no other framing checks; only crc fault reported.
// - failed frame is still relayed onward byte by byte.
// - bytes go out lsb first; crc consumes bits in that serial order.
// - transmitter covers every byte except the crc bytes.
// - transmitter appends 16-bit remainder as two trailing bytes.
// - each division step xors generator into leading 17 bits until 16 remain.
// - every command frame propagates along the chain whatever its address.
// - single read answered only by device whose address matches.
// - addressed device, if not still sending a response, returns response with data length equal to request.
// - read data byte is length minus one, 0..127 gives 1..128 bytes.
`ifndef DFCC_CFG_SVH
`define DFCC_CFG_SVH
`define DFCC_CRC_PRESET  16'hffff
`define DFCC_CRC_POLY_R  16'ha001
`define DFCC_CRC_GOOD    16'h0000
`define DFCC_FT_BIT      7
`define DFCC_REQ_HI      6
`define DFCC_REQ_LO      4
`define DFCC_SIZE_HI     2
`define DFCC_SIZE_LO     0
`define DFCC_REQ_SREAD   3'h0
`define DFCC_LEN_MASK    8'h7f
`define DFCC_RSP_HDR     8'h00
`define DFCC_CMD_LEN     7'h07
`endif

// ==== src/dfcc_pkg.sv ====
package dfcc_pkg;
  typedef enum logic [2:0] {
    DFCC_RX_INIT = 3'b000,
    DFCC_RX_ADDR = 3'b001,
    DFCC_RX_RAH  = 3'b010,
    DFCC_RX_RAL  = 3'b011,
    DFCC_RX_DATA = 3'b100,
    DFCC_RX_CRC  = 3'b101
  } dfcc_rx_t;
  typedef enum logic [2:0] {
    DFCC_TX_IDLE = 3'b000,
    DFCC_TX_HDR  = 3'b001,
    DFCC_TX_ADDR = 3'b010,
    DFCC_TX_RAH  = 3'b011,
    DFCC_TX_RAL  = 3'b100,
    DFCC_TX_DATA = 3'b101,
    DFCC_TX_CRCL = 3'b110,
    DFCC_TX_CRCH = 3'b111
  } dfcc_tx_t;
endpackage

// ==== src/dfcc_crc_byte.sv ====
// Purpose: one-byte step of the frame crc, serial bit order
// Assumes: combinational, used for both receive and transmit
// Notes: unrolled over eight bits, lsb first
`timescale 1ns/100ps
`include "dfcc_cfg.svh"
module dfcc_crc_byte (
  input  wire logic [15:0] crc_in,
  input  wire logic [7:0]  data_in,
  output logic      [15:0] crc_out
);
  logic [15:0] c;
  always_comb begin
    c = crc_in;
    for (int i = 0; i < 8; i++) begin
      // reflected form: the shift-out bit stands for the leading of 17 bits
      if (c[0] ^ data_in[i]) begin
        c = (c >> 1) ^ `DFCC_CRC_POLY_R;
      end else begin
        c = c >> 1;
      end
    end
    crc_out = c;
  end
endmodule

// ==== src/dfcc_top.sv ====
// Purpose: crc check on received frames, relay, single-read answer with crc
// Assumes: frame bytes arrive on rx_valid with rx_last on the final crc byte
// Notes: register contents come from a read port with one-cycle latency
`timescale 1ns/100ps
`include "dfcc_cfg.svh"
module dfcc_top
  import dfcc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [7:0]  dev_addr,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_byte,
  input  wire logic        rx_last,
  output logic             fwd_valid,
  output logic [7:0]       fwd_byte,
  output logic             cmd_ok,
  output logic [15:0]      cmd_reg_addr,
  output logic [7:0]       cmd_len_m1,
  output logic             crc_fault,
  input  wire logic        fault_clear,
  output logic             rd_req,
  output logic [15:0]      rd_addr,
  input  wire logic [7:0]  rd_data,
  output logic             tx_valid,
  output logic [7:0]       tx_byte,
  input  wire logic        tx_ready,
  output logic             tx_busy
);
  dfcc_rx_t    rx_state_reg;
  logic [15:0] rx_crc_reg;
  logic [15:0] rx_crc_next;
  logic [7:0]  init_reg;
  logic [7:0]  addr_reg;
  logic [15:0] ra_reg;
  logic [7:0]  data_reg;
  logic        sread_hit;
  dfcc_tx_t    tx_state_reg;
  logic [15:0] tx_crc_reg;
  logic [15:0] tx_crc_next;
  logic [7:0]  tx_cnt_reg;
  logic [15:0] tx_ra_reg;
  logic [7:0]  tx_len_reg;
  logic [7:0]  tx_byte_next;
  logic        tx_fire;
  logic        rd_wait_reg;

  dfcc_crc_byte u_rx_crc (
    .crc_in  (rx_crc_reg),
    .data_in (rx_byte),
    .crc_out (rx_crc_next)
  );

  dfcc_crc_byte u_tx_crc (
    .crc_in  (tx_crc_reg),
    .data_in (tx_byte_next),
    .crc_out (tx_crc_next)
  );

  // relay every byte unchanged, good or bad, whoever is addressed
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fwd_valid <= 1'b0;
      fwd_byte  <= 8'h00;
    end else begin
      fwd_valid <= rx_valid;
      fwd_byte  <= rx_byte;
    end
  end

  // receive field tracking; the fixed seven-byte read frame is the only one decoded
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rx_state_reg <= DFCC_RX_INIT;
      init_reg     <= 8'h00;
      addr_reg     <= 8'h00;
      ra_reg       <= 16'h0000;
      data_reg     <= 8'h00;
    end else if (rx_valid) begin
      if (rx_last) begin
        rx_state_reg <= DFCC_RX_INIT;
      end else begin
        unique case (rx_state_reg)
          DFCC_RX_INIT: begin
            init_reg     <= rx_byte;
            rx_state_reg <= DFCC_RX_ADDR;
          end
          DFCC_RX_ADDR: begin
            addr_reg     <= rx_byte;
            rx_state_reg <= DFCC_RX_RAH;
          end
          DFCC_RX_RAH: begin
            ra_reg[15:8] <= rx_byte;
            rx_state_reg <= DFCC_RX_RAL;
          end
          DFCC_RX_RAL: begin
            ra_reg[7:0]  <= rx_byte;
            rx_state_reg <= DFCC_RX_DATA;
          end
          DFCC_RX_DATA: begin
            data_reg     <= rx_byte;
            rx_state_reg <= DFCC_RX_CRC;
          end
          DFCC_RX_CRC: begin
            rx_state_reg <= DFCC_RX_CRC;
          end
          default: begin
            rx_state_reg <= DFCC_RX_INIT;
          end
        endcase
      end
    end
  end

  // running check over the whole frame including its crc bytes
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rx_crc_reg <= `DFCC_CRC_PRESET;
    end else if (rx_valid) begin
      rx_crc_reg <= rx_last ? `DFCC_CRC_PRESET : rx_crc_next;
    end
  end

  // decode only after the check passes; a failed frame skips every other test
  assign sread_hit = init_reg[`DFCC_FT_BIT]
                   && (init_reg[`DFCC_REQ_HI:`DFCC_REQ_LO] == `DFCC_REQ_SREAD)
                   && (init_reg[`DFCC_SIZE_HI:`DFCC_SIZE_LO] == 3'h0)
                   && (addr_reg == dev_addr);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cmd_ok       <= 1'b0;
      cmd_reg_addr <= 16'h0000;
      cmd_len_m1   <= 8'h00;
    end else begin
      // frame length is not verified here: a crc error reports nothing else
      cmd_ok <= rx_valid && rx_last && (rx_crc_next == `DFCC_CRC_GOOD)
                && sread_hit && !tx_busy;
      if (rx_valid && rx_last) begin
        cmd_reg_addr <= ra_reg;
        cmd_len_m1   <= data_reg & `DFCC_LEN_MASK;
      end
    end
  end

  // sticky fault; a new failure in the clear cycle wins
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      crc_fault <= 1'b0;
    end else if (rx_valid && rx_last && (rx_crc_next != `DFCC_CRC_GOOD)) begin
      crc_fault <= 1'b1;
    end else if (fault_clear) begin
      crc_fault <= 1'b0;
    end
  end

  // response byte source per state
  always_comb begin
    unique case (tx_state_reg)
      DFCC_TX_HDR:  tx_byte_next = `DFCC_RSP_HDR | tx_len_reg;
      DFCC_TX_ADDR: tx_byte_next = dev_addr;
      DFCC_TX_RAH:  tx_byte_next = tx_ra_reg[15:8];
      DFCC_TX_RAL:  tx_byte_next = tx_ra_reg[7:0];
      DFCC_TX_DATA: tx_byte_next = rd_data;
      DFCC_TX_CRCL: tx_byte_next = tx_crc_reg[7:0];
      DFCC_TX_CRCH: tx_byte_next = tx_crc_reg[15:8];
      default:      tx_byte_next = 8'h00;
    endcase
  end

  // data states wait one cycle for the registered read port
  assign tx_fire = (tx_state_reg != DFCC_TX_IDLE) && (!tx_valid || tx_ready)
                   && !(tx_state_reg == DFCC_TX_DATA && rd_wait_reg);
  assign tx_busy = (tx_state_reg != DFCC_TX_IDLE);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rd_wait_reg <= 1'b0;
      rd_req      <= 1'b0;
      rd_addr     <= 16'h0000;
    end else begin
      rd_req      <= 1'b0;
      rd_wait_reg <= 1'b0;
      if (tx_fire && (tx_state_reg == DFCC_TX_RAL || tx_state_reg == DFCC_TX_DATA)
          && !(tx_state_reg == DFCC_TX_DATA && tx_cnt_reg == 8'h00)) begin
        rd_req      <= 1'b1;
        rd_wait_reg <= 1'b1;
        rd_addr     <= (tx_state_reg == DFCC_TX_RAL) ? tx_ra_reg : rd_addr + 16'h0001;
      end
    end
  end

  // response sequencer: header, address, register address, data, crc
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tx_state_reg <= DFCC_TX_IDLE;
      tx_crc_reg   <= `DFCC_CRC_PRESET;
      tx_cnt_reg   <= 8'h00;
      tx_ra_reg    <= 16'h0000;
      tx_len_reg   <= 8'h00;
      tx_valid     <= 1'b0;
      tx_byte      <= 8'h00;
    end else begin
      if (tx_valid && tx_ready) begin
        tx_valid <= 1'b0;
      end
      if (tx_state_reg == DFCC_TX_IDLE) begin
        if (cmd_ok) begin
          tx_state_reg <= DFCC_TX_HDR;
          tx_crc_reg   <= `DFCC_CRC_PRESET;
          tx_ra_reg    <= cmd_reg_addr;
          tx_len_reg   <= cmd_len_m1;
          tx_cnt_reg   <= cmd_len_m1;
        end
      end else if (tx_fire) begin
        tx_valid <= 1'b1;
        tx_byte  <= tx_byte_next;
        if (tx_state_reg != DFCC_TX_CRCL && tx_state_reg != DFCC_TX_CRCH) begin
          tx_crc_reg <= tx_crc_next;
        end
        unique case (tx_state_reg)
          DFCC_TX_HDR:  tx_state_reg <= DFCC_TX_ADDR;
          DFCC_TX_ADDR: tx_state_reg <= DFCC_TX_RAH;
          DFCC_TX_RAH:  tx_state_reg <= DFCC_TX_RAL;
          DFCC_TX_RAL:  tx_state_reg <= DFCC_TX_DATA;
          DFCC_TX_DATA: begin
            if (tx_cnt_reg == 8'h00) begin
              tx_state_reg <= DFCC_TX_CRCL;
            end else begin
              tx_cnt_reg <= tx_cnt_reg - 8'h01;
            end
          end
          DFCC_TX_CRCL: tx_state_reg <= DFCC_TX_CRCH;
          DFCC_TX_CRCH: tx_state_reg <= DFCC_TX_IDLE;
          default:      tx_state_reg <= DFCC_TX_IDLE;
        endcase
      end
    end
  end
endmodule

// ==== tb/dfcc_host_model.sv ====
// Purpose: host side model, register read port and response sink
// Assumes: rd_data is wanted the cycle after rd_req
// Notes: sink stalls every other cycle so held response bytes get seen
`timescale 1ns/100ps
module dfcc_host_model (
  input  wire logic        clk,
  input  wire logic        rd_req,
  input  wire logic [15:0] rd_addr,
  output logic      [7:0]  rd_data,
  output logic             tx_ready
);
  initial begin
    rd_data = 8'h00;
    tx_ready = 1'b0;
  end
  // stale data is inverted so a late sample never matches
  always @(posedge clk) begin
    rd_data <= rd_req ? (rd_addr[7:0] ^ 8'h5a) : ~rd_data;
    tx_ready <= ~tx_ready;
  end
endmodule

// ==== tb/dfcc_top_properties.sv ====
// Purpose: port level properties of the frame crc block
// Assumes: single clock, async active high reset
// Notes: bound into every dfcc_top instance
`timescale 1ns/100ps
module dfcc_top_checker (
  input wire logic       clk,
  input wire logic       reset,
  input wire logic       rx_valid,
  input wire logic [7:0] rx_byte,
  input wire logic       rx_last,
  input wire logic       fwd_valid,
  input wire logic [7:0] fwd_byte,
  input wire logic       cmd_ok,
  input wire logic       crc_fault,
  input wire logic       fault_clear,
  input wire logic       rd_req,
  input wire logic       tx_valid,
  input wire logic [7:0] tx_byte,
  input wire logic       tx_ready,
  input wire logic       tx_busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  AST_FWD_COPY: assert property (rx_valid |=> fwd_valid && fwd_byte == $past(rx_byte))
    else $error("relay byte missing or wrong");
  AST_FWD_QUIET: assert property (!rx_valid |=> !fwd_valid)
    else $error("relay without received byte");
  AST_OK_CAUSE: assert property (cmd_ok |-> $past(rx_valid && rx_last) && !$rose(crc_fault))
    else $error("command accepted without good frame end");
  AST_OK_PULSE: assert property (cmd_ok |=> !cmd_ok)
    else $error("command pulse too long");
  AST_FAULT_CAUSE: assert property ($rose(crc_fault) |-> $past(rx_valid && rx_last))
    else $error("fault raised away from frame end");
  AST_FAULT_STICKY: assert property (crc_fault && !fault_clear |=> crc_fault)
    else $error("fault dropped without clear");
  AST_FAULT_CLEAR: assert property (fault_clear && !(rx_valid && rx_last) |=> !crc_fault)
    else $error("fault not cleared");
  AST_TX_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
    else $error("response byte changed before accept");
  AST_TX_START: assert property (cmd_ok |-> ##2 tx_valid)
    else $error("response did not start");
  AST_RD_BUSY: assert property (rd_req |-> tx_busy)
    else $error("register read outside response");
  cover property (cmd_ok);
  cover property ($rose(crc_fault));
  cover property (tx_valid && !tx_ready ##1 tx_valid);
endmodule
bind dfcc_top dfcc_top_checker chk_i (.clk(clk), .reset(reset), .rx_valid(rx_valid),
  .rx_byte(rx_byte), .rx_last(rx_last), .fwd_valid(fwd_valid), .fwd_byte(fwd_byte),
  .cmd_ok(cmd_ok), .crc_fault(crc_fault), .fault_clear(fault_clear), .rd_req(rd_req),
  .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_ready(tx_ready), .tx_busy(tx_busy));

// ==== tb/daisy_frame_crc_check_test.sv ====
// Purpose: self-checking bench for the frame crc block
// Assumes: inputs change at the falling edge
// Notes: table rows first, then fault latch and busy cases
`timescale 1ns/100ps
module daisy_frame_crc_check_test;
  import dfcc_pkg::*;
  typedef struct {logic [7:0] init; logic [7:0] addr; logic [7:0] len; logic bad; logic ok;} dfcc_row_t;
  logic        clk, reset, rx_valid, rx_last, fault_clear, fwd_valid, cmd_ok, crc_fault;
  logic        rd_req, tx_valid, tx_ready, tx_busy;
  logic [7:0]  dev_addr, rx_byte, fwd_byte, cmd_len_m1, rd_data, tx_byte;
  logic [15:0] cmd_reg_addr, rd_addr, c;
  int          n_fail, checked, n_fwd;
  logic [7:0]  rsp[$];
  dfcc_row_t   rows[7] = '{'{8'h80, 8'h02, 8'h00, 0, 1}, '{8'h80, 8'h02, 8'h82, 0, 1},
    '{8'h80, 8'h02, 8'h7f, 0, 1}, '{8'h80, 8'h03, 8'h00, 0, 0}, '{8'h81, 8'h02, 8'h00, 0, 0},
    '{8'h90, 8'h02, 8'h00, 0, 0}, '{8'h80, 8'h02, 8'h00, 1, 0}};
  dfcc_top dut (.clk(clk), .reset(reset), .dev_addr(dev_addr), .rx_valid(rx_valid),
    .rx_byte(rx_byte), .rx_last(rx_last), .fwd_valid(fwd_valid), .fwd_byte(fwd_byte),
    .cmd_ok(cmd_ok), .cmd_reg_addr(cmd_reg_addr), .cmd_len_m1(cmd_len_m1),
    .crc_fault(crc_fault), .fault_clear(fault_clear), .rd_req(rd_req), .rd_addr(rd_addr),
    .rd_data(rd_data), .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_ready(tx_ready),
    .tx_busy(tx_busy));
  dfcc_host_model host (.clk(clk), .rd_req(rd_req), .rd_addr(rd_addr), .rd_data(rd_data),
    .tx_ready(tx_ready));
  function automatic logic [15:0] crc_upd(logic [15:0] cv, logic [7:0] b);
    cv = cv ^ {8'h00, b};
    for (int i = 0; i < 8; i++) cv = cv[0] ? (cv >> 1) ^ 16'ha001 : cv >> 1;
    return cv;
  endfunction
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // host frame: size field zero for reads, crc low byte first
  task automatic send(logic [7:0] f[5], logic bad, logic clr);
    logic [15:0] cs;
    logic [7:0]  b[7];
    cs = 16'hffff;
    for (int i = 0; i < 5; i++) begin
      b[i] = f[i];
      cs = crc_upd(cs, f[i]);
    end
    b[5] = cs[7:0] ^ {7'h00, bad};
    b[6] = cs[15:8];
    n_fwd = 0;
    for (int i = 0; i < 7; i++) begin
      @(negedge clk);
      rx_valid = 1'b1;
      rx_byte = b[i];
      rx_last = (i == 6);
      fault_clear = clr && (i == 6);
    end
    @(negedge clk);
    rx_valid = 1'b0;
    rx_last = 1'b0;
    fault_clear = 1'b0;
  endtask
  task automatic drain();
    repeat (3) @(negedge clk);
    // the last crc byte is still held after busy drops, wait for its accept too
    for (int t = 0; t < 2000 && (tx_busy !== 1'b0 || tx_valid !== 1'b0); t++) @(negedge clk);
    @(negedge clk);
  endtask
  always @(posedge clk) if (fwd_valid) n_fwd++;
  always @(posedge clk) if (tx_valid && tx_ready) rsp.push_back(tx_byte);
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    #(25ns * 20000);
    n_fail++;
    give_verdict();
  end
  initial begin
    {reset, rx_valid, rx_last, fault_clear, rx_byte} = {4'h8, 8'h00};
    dev_addr = 8'h02;
    repeat (10) @(negedge clk);
    chk("reset_out", {fwd_valid, cmd_ok, crc_fault, tx_valid, rd_req}, 16'h0000);
    reset = 1'b0;
    foreach (rows[k]) begin
      rsp.delete();
      send('{rows[k].init, rows[k].addr, 8'h01, 8'(8'h20 + k), rows[k].len}, rows[k].bad, 0);
      chk("cmd_ok", cmd_ok, rows[k].ok);
      chk("crc_fault", crc_fault, rows[k].bad);
      if (rows[k].ok) chk("cmd_len", cmd_len_m1, rows[k].len & 8'h7f);
      if (rows[k].ok) chk("cmd_reg", cmd_reg_addr, {8'h01, 8'(8'h20 + k)});
      drain();
      chk("fwd_count", n_fwd, 7);
      chk("rsp_len", rsp.size(), rows[k].ok ? (rows[k].len & 8'h7f) + 7 : 0);
      c = 16'hffff;
      foreach (rsp[i]) c = crc_upd(c, rsp[i]);
      if (rows[k].ok) chk("rsp_crc", c, 16'h0000);
      if (rows[k].ok) chk("rsp_hdr", rsp[0], rows[k].len & 8'h7f);
      if (rows[k].ok) chk("rsp_dev", rsp[1], 8'h02);
      if (rows[k].ok) chk("rsp_rah", rsp[2], 8'h01);
      if (rows[k].ok) chk("rsp_ral", rsp[3], 8'(8'h20 + k));
      for (int i = 4; i < rsp.size() - 2; i++) chk("rsp_data", rsp[i], 8'(8'h20 + k + i - 4) ^ 8'h5a);
    end
    repeat (5) @(negedge clk);
    chk("fault_hold", crc_fault, 1);
    send('{8'h80, 8'h02, 8'h01, 8'h20, 8'h00}, 1, 1);
    chk("fault_set_wins", crc_fault, 1);
    @(negedge clk);
    fault_clear = 1'b1;
    @(negedge clk);
    fault_clear = 1'b0;
    chk("fault_clear", crc_fault, 0);
    send('{8'h80, 8'h02, 8'h01, 8'h20, 8'h00}, 0, 0);
    send('{8'h80, 8'h02, 8'h01, 8'h21, 8'h00}, 0, 0);
    chk("busy_refuse", cmd_ok, 0);
    drain();
    give_verdict();
  end
endmodule
